// ### design/sap_pkg.sv
// Constants and types shared by the serial audio clocking port
package sap_pkg;

  // Register byte offsets
  localparam logic [3:0] OFS_GLOBAL = 4'h0;
  localparam logic [3:0] OFS_MODE   = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;

  // Global control fields
  localparam int unsigned CONTROL_PORT_ENABLE_BIT = 7;
  localparam int unsigned XTAL_BIT  = 2;
  localparam int unsigned DIV_LSB   = 0;

  // Mode control fields
  localparam int unsigned ROLE_LSB = 0;
  localparam int unsigned FMT_LSB  = 2;

  // Status fields
  localparam int unsigned ST_SPEED_LSB = 0;
  localparam int unsigned ST_MASTER    = 2;
  localparam int unsigned ST_RUNNING   = 3;
  localparam int unsigned ST_CONTROL_PORT_ENABLE     = 4;
  localparam int unsigned ST_MCLK_IN   = 5;

  // Reset values
  localparam logic [1:0] DIV_RST  = 2'h0;
  localparam logic [1:0] ROLE_RST = 2'h0;
  localparam logic [1:0] FMT_RST  = 2'h0;

  // Serial format select codes
  typedef enum logic [1:0] {
    FMT_LJ  = 2'b00,
    FMT_I2S = 2'b01,
    FMT_TDM = 2'b10,
    FMT_RSV = 2'b11
  } sap_fmt_t;

  // Speed and clock role codes
  typedef enum logic [1:0] {
    ROLE_SS    = 2'b00,
    ROLE_DS    = 2'b01,
    ROLE_QS    = 2'b10,
    ROLE_SLAVE = 2'b11
  } sap_role_t;

  // Start-up and strap capture
  localparam int unsigned START_CYCLES_DEF = 524288;
  localparam logic [19:0] CAPTURE_CYCLE    = 20'h00002;

  // Frame geometry
  localparam logic [7:0] FRAME_LAST_TWO = 8'h3F;
  localparam logic [7:0] FRAME_LAST_TDM = 8'hFF;
  localparam logic [7:0] SLOT_LEN       = 8'h20;
  localparam logic [7:0] TDM_SYNC_HIGH  = 8'h80;
  localparam logic [8:0] SAMPLE_BITS    = 9'h018;
  localparam logic [4:0] MSB_INDEX      = 5'h17;
  localparam logic [8:0] IDX_SAT        = 9'h1FF;

  // Bit clock half periods in system clocks per speed, before divider
  localparam logic [7:0] TWO_HALF [4] = '{8'h08, 8'h04, 8'h02, 8'h02};
  localparam logic [7:0] TDM_HALF [4] = '{8'h02, 8'h01, 8'h01, 8'h01};

  // Slave auto-detect thresholds in system clocks per frame
  localparam logic [11:0] THR_SS = 12'h258;
  localparam logic [11:0] THR_DS = 12'h12C;

endpackage : sap_pkg

// ### design/sap_port.sv
// Serial audio output port with clock mastering and format selection
//
// Local design decisions: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`default_nettype none

module sap_port #(
  parameter int unsigned START_CYCLES = sap_pkg::START_CYCLES_DEF
) (
  input  wire logic                clk_i,
  input  wire logic                rstn_i,
  input  wire logic [3:0]          avs_address_i,
  input  wire logic                avs_read_i,
  input  wire logic                avs_write_i,
  input  wire logic [31:0]         avs_writedata_i,
  output var  logic [31:0]         avs_readdata_o,
  output      logic                avs_waitrequest_o,
  input  wire logic                format_select_high_i,
  input  wire logic                format_select_low_i,
  input  wire logic                speed_role_select_high_i,
  input  wire logic                speed_role_select_low_i,
  input  wire logic [1:0]          clock_divider_strap_i,
  input  wire logic                crystal_enable_strap_i,
  input  wire logic                crystal_clock_input_i,
  output      logic                crystal_drive_output_o,
  input  wire logic                mclk_pin_i,
  output      logic                mclk_pin_o,
  output      logic                mclk_pin_oe_o,
  input  wire logic                bit_clock_pin_i,
  output      logic                bit_clock_pin_o,
  output      logic                bit_clock_pin_oe_o,
  input  wire logic                frame_clock_pin_i,
  output      logic                frame_clock_pin_o,
  output      logic                frame_clock_pin_oe_o,
  output      logic                first_data_output_o,
  output      logic                second_data_output_o,
  output      logic                complementary_tdm_output_o,
  output      logic                fourth_data_output_o,
  output      logic                ctrl_pins_repurposed_o,
  input  wire logic [7:0][23:0]    ch_sample_i,
  output var  logic                sample_take_o
);

  // Pin synchronisers; only sync2 is read by logic
  logic [10:0] sync1;
  logic [10:0] sync2;
  wire  logic [10:0] async_in;
  assign async_in = {crystal_enable_strap_i, clock_divider_strap_i,
                     format_select_high_i, format_select_low_i,
                     speed_role_select_high_i, speed_role_select_low_i,
                     crystal_clock_input_i, mclk_pin_i,
                     bit_clock_pin_i, frame_clock_pin_i};

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sync1 <= 11'h000;
      sync2 <= 11'h000;
    end
    else
    begin
      sync1 <= async_in;
      sync2 <= sync1;
    end
  end

  wire logic xtal_s;
  wire logic mclk_s;
  wire logic bclk_s;
  wire logic frame_s;
  assign xtal_s  = sync2[3];
  assign mclk_s  = sync2[2];
  assign bclk_s  = sync2[1];
  assign frame_s = sync2[0];

  // Start-up counter and strap latch; straps are caught after sync settles
  logic [19:0] start_cnt;
  logic        running;
  logic [6:0]  strap_q;

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      start_cnt <= 20'h00000;
      running   <= 1'b0;
      strap_q   <= 7'h00;
    end
    else if (!running)
    begin
      start_cnt <= start_cnt + 20'h00001;
      if (start_cnt == sap_pkg::CAPTURE_CYCLE)
        strap_q <= sync2[10:4];
      if (start_cnt == 20'(START_CYCLES - 1))
        running <= 1'b1;
    end
  end

  // Avalon slave: one wait cycle per access, then the answer
  logic        ack;
  logic        control_port_enable;
  logic        reg_xtal;
  logic [1:0]  reg_div;
  logic [1:0]  reg_role;
  logic [1:0]  reg_fmt;
  wire  logic  req;
  wire  logic  wr_take;
  wire  logic  sel_global;
  wire  logic  sel_mode;
  wire  logic  sel_status;
  wire  logic [31:0] rd_mux;
  wire  logic [31:0] status_word;

  assign req               = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack;
  assign wr_take           = avs_write_i & ack;
  assign sel_global        = avs_address_i == sap_pkg::OFS_GLOBAL;
  assign sel_mode          = avs_address_i == sap_pkg::OFS_MODE;
  assign sel_status        = avs_address_i == sap_pkg::OFS_STATUS;

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ack            <= 1'b0;
      avs_readdata_o <= 32'h00000000;
    end
    else
    begin
      ack <= req & ~ack;
      if (avs_read_i & ~ack)
        avs_readdata_o <= rd_mux;
    end
  end

  // Enable is sticky: writing zero cannot hand control back to straps
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      control_port_enable    <= 1'b0;
      reg_xtal <= 1'b0;
      reg_div  <= sap_pkg::DIV_RST;
      reg_role <= sap_pkg::ROLE_RST;
      reg_fmt  <= sap_pkg::FMT_RST;
    end
    else if (wr_take & sel_global)
    begin
      if (avs_writedata_i[sap_pkg::CONTROL_PORT_ENABLE_BIT])
        control_port_enable <= 1'b1;
      reg_xtal <= avs_writedata_i[sap_pkg::XTAL_BIT];
      reg_div  <= avs_writedata_i[sap_pkg::DIV_LSB +: 2];
    end
    else if (wr_take & sel_mode)
    begin
      reg_role <= avs_writedata_i[sap_pkg::ROLE_LSB +: 2];
      reg_fmt  <= avs_writedata_i[sap_pkg::FMT_LSB +: 2];
    end
  end

  // Effective configuration: registers win once enabled
  wire logic              eff_xtal;
  wire logic [1:0]        eff_div;
  sap_pkg::sap_fmt_t      eff_fmt;
  sap_pkg::sap_role_t     eff_role;
  sap_pkg::sap_role_t     det_speed;
  sap_pkg::sap_role_t     speed_used;
  wire logic              master;
  wire logic              is_tdm;
  wire logic              is_i2s;
  wire logic              is_rsv;
  wire logic              first_lvl;
  wire logic [2:0]        div_mul;

  assign eff_xtal  = control_port_enable ? reg_xtal : strap_q[6];
  assign eff_div   = control_port_enable ? reg_div : strap_q[5:4];
  assign eff_fmt   = sap_pkg::sap_fmt_t'(control_port_enable ? reg_fmt : strap_q[3:2]);
  assign eff_role  = sap_pkg::sap_role_t'(control_port_enable ? reg_role : strap_q[1:0]);
  assign master    = eff_role != sap_pkg::ROLE_SLAVE;
  assign is_tdm    = eff_fmt == sap_pkg::FMT_TDM;
  assign is_i2s    = eff_fmt == sap_pkg::FMT_I2S;
  assign is_rsv    = eff_fmt == sap_pkg::FMT_RSV;
  assign first_lvl = ~is_i2s;
  assign div_mul   = {1'b0, eff_div} + 3'h1;
  assign speed_used = master ? eff_role : det_speed;

  assign status_word = {26'h0000000, mclk_s, control_port_enable, running, master, speed_used};
  assign rd_mux = sel_global ? {24'h000000, control_port_enable, 4'h0, reg_xtal, reg_div} :
                  sel_mode   ? {28'h0000000, reg_fmt, reg_role} :
                  sel_status ? status_word : 32'h00000000;

  // Master clock pin: crystal copy out, or an input when external
  assign mclk_pin_oe_o          = eff_xtal;
  assign mclk_pin_o             = eff_xtal & xtal_s;
  assign crystal_drive_output_o = eff_xtal & ~xtal_s;
  assign ctrl_pins_repurposed_o = control_port_enable;

  // Master bit and frame clock generator from the divider table
  logic [7:0] hcnt;
  logic [7:0] fcnt;
  logic       m_bclk;
  logic       m_frame;
  wire  logic [7:0] half_base;
  wire  logic [7:0] half_len;
  wire  logic [7:0] frame_last;
  wire  logic [7:0] next_fcnt;
  wire  logic       hit;
  wire  logic       m_shift;
  wire  logic       m_fr;

  assign half_base  = is_tdm ? sap_pkg::TDM_HALF[eff_role] : sap_pkg::TWO_HALF[eff_role];
  assign half_len   = 8'(half_base * div_mul);
  assign hit        = hcnt == half_len - 8'h01;
  assign m_shift    = running & master & hit & m_bclk;
  assign frame_last = is_tdm ? sap_pkg::FRAME_LAST_TDM : sap_pkg::FRAME_LAST_TWO;
  assign next_fcnt  = (fcnt == frame_last) ? 8'h00 : fcnt + 8'h01;
  assign m_fr       = is_tdm ? (next_fcnt < sap_pkg::TDM_SYNC_HIGH)
                             : ((next_fcnt < sap_pkg::SLOT_LEN) ^ is_i2s);

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      hcnt    <= 8'h00;
      fcnt    <= 8'hFF;
      m_bclk  <= 1'b0;
      m_frame <= 1'b0;
    end
    else if (!running | !master)
    begin
      hcnt    <= 8'h00;
      fcnt    <= frame_last;
      m_bclk  <= 1'b0;
      m_frame <= 1'b0;
    end
    else if (hit)
    begin
      hcnt   <= 8'h00;
      m_bclk <= ~m_bclk;
      if (m_bclk)
      begin
        fcnt    <= next_fcnt;
        m_frame <= m_fr;
      end
    end
    else
      hcnt <= hcnt + 8'h01;
  end

  // Master drives the clock pins; slave listens
  assign bit_clock_pin_o      = m_bclk;
  assign bit_clock_pin_oe_o   = master;
  assign frame_clock_pin_o    = m_frame;
  assign frame_clock_pin_oe_o = master;

  // Slave edge detect and speed auto-detect on frame period
  logic        bclk_prev;
  logic        frame_prev;
  logic [11:0] pcnt;
  wire  logic  s_shift;
  wire  logic  s_rise;
  wire  logic [11:0] thr_ss_m;
  wire  logic [11:0] thr_ds_m;

  assign s_shift  = running & ~master & bclk_prev & ~bclk_s;
  assign s_rise   = frame_s & ~frame_prev;
  assign thr_ss_m = 12'(sap_pkg::THR_SS * div_mul);
  assign thr_ds_m = 12'(sap_pkg::THR_DS * div_mul);

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      bclk_prev  <= 1'b0;
      frame_prev <= 1'b0;
      pcnt       <= 12'h000;
      det_speed  <= sap_pkg::ROLE_SS;
    end
    else
    begin
      bclk_prev  <= bclk_s;
      frame_prev <= frame_s;
      if (s_rise)
      begin
        pcnt <= 12'h000;
        if (!master)
          det_speed <= (pcnt >= thr_ss_m) ? sap_pkg::ROLE_SS :
                       (pcnt >= thr_ds_m) ? sap_pkg::ROLE_DS : sap_pkg::ROLE_QS;
      end
      else if (pcnt != 12'hFFF)
        pcnt <= pcnt + 12'h001;
    end
  end

  // Serializer shared by both roles; shifts on bit clock falling edges
  logic [8:0]       idx;
  logic             fr_prev;
  logic [3:0]       dout;
  logic [7:0][23:0] shadow;
  wire  logic       shift;
  wire  logic       fr;
  wire  logic       edge_ev;
  wire  logic       boundary;
  wire  logic       frame_start;
  wire  logic       chs;
  wire  logic [8:0] idx_inc;
  wire  logic [8:0] next_idx;
  wire  logic [8:0] bit_pos;
  wire  logic       valid2;
  wire  logic [4:0] bsel2;
  wire  logic [4:0] tb;
  wire  logic [2:0] tslot;
  wire  logic       validt;
  wire  logic       tdm_bit;
  wire  logic [3:0] pair_bit;
  wire  logic [3:0] next_dout;
  wire  logic [7:0][23:0] cur;

  assign shift       = m_shift | s_shift;
  assign fr          = master ? m_fr : frame_s;
  assign edge_ev     = fr != fr_prev;
  assign boundary    = is_tdm ? (edge_ev & fr) : edge_ev;
  assign frame_start = is_tdm ? boundary : (edge_ev & (fr == first_lvl));
  assign chs         = fr != first_lvl;
  assign idx_inc     = (idx == sap_pkg::IDX_SAT) ? idx : idx + 9'h001;
  assign next_idx    = boundary ? 9'h000 : idx_inc;
  // I2S data lags the frame edge by one bit clock
  assign bit_pos     = next_idx - {8'h00, is_i2s};
  assign valid2      = bit_pos < sap_pkg::SAMPLE_BITS;
  assign bsel2       = sap_pkg::MSB_INDEX - bit_pos[4:0];
  assign tb          = next_idx[4:0];
  assign tslot       = next_idx[7:5];
  assign validt      = ~next_idx[8] & (tb < sap_pkg::SAMPLE_BITS[4:0]);
  assign cur         = frame_start ? ch_sample_i : shadow;
  assign tdm_bit     = validt & cur[tslot][sap_pkg::MSB_INDEX - tb];

  // One pair of channels per two-channel data output
  for (genvar k = 0; k < 4; k++)
  begin : g_pair
    assign pair_bit[k] = valid2 & cur[{2'(k), chs}][bsel2];
  end

  // Reserved format sends silence; TDM holds the second and fourth outputs low
  assign next_dout = is_rsv ? 4'h0 :
                     is_tdm ? {1'b0, ~tdm_bit, 1'b0, tdm_bit} : pair_bit;

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      idx           <= 9'h000;
      fr_prev       <= 1'b0;
      dout          <= 4'h0;
      shadow        <= '0;
      sample_take_o <= 1'b0;
    end
    else if (!running)
    begin
      fr_prev       <= is_tdm ? 1'b0 : ~first_lvl;
      dout          <= 4'h0;
      sample_take_o <= 1'b0;
    end
    else
    begin
      sample_take_o <= shift & frame_start;
      if (shift)
      begin
        idx     <= next_idx;
        fr_prev <= fr;
        dout    <= next_dout;
        if (frame_start)
          shadow <= ch_sample_i;
      end
    end
  end

  assign first_data_output_o        = dout[0];
  assign second_data_output_o       = dout[1];
  assign complementary_tdm_output_o = dout[2];
  assign fourth_data_output_o       = dout[3];

  // Helper: master bit clocks between frame clock rises
  logic [8:0] fall_cnt;
  logic       rise_seen;

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      fall_cnt  <= 9'h000;
      rise_seen <= 1'b0;
    end
    else if (!running | !master)
      rise_seen <= 1'b0;
    else if (m_shift)
    begin
      fall_cnt <= (m_fr & ~m_frame) ? 9'h001 : fall_cnt + 9'h001;
      if (m_fr & ~m_frame)
        rise_seen <= 1'b1;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  sequence s_cp_write;
    wr_take && sel_global && avs_writedata_i[sap_pkg::CONTROL_PORT_ENABLE_BIT];
  endsequence

  sequence s_master_rise;
    m_shift && m_fr && !m_frame && rise_seen;
  endsequence

  a_control_port_enable_set:
    assert property (s_cp_write |=> control_port_enable [*3])
    else $error("enable bit not set by write");

  a_control_port_enable_only_write:
    assert property (!control_port_enable && !(wr_take && sel_global) |=> !control_port_enable)
    else $error("enable bit set without write");

  a_strap_ignored:
    assert property (control_port_enable && !wr_take |=> $stable(eff_fmt) && $stable(eff_role))
    else $error("config moved while straps ignored");

  a_mclk_copy:
    assert property (eff_xtal && $stable(eff_xtal)
                     |-> mclk_pin_oe_o && mclk_pin_o == $past(crystal_clock_input_i, 2))
    else $error("master clock pin not a crystal copy");

  a_mclk_input:
    assert property (!eff_xtal |-> !mclk_pin_oe_o && !crystal_drive_output_o)
    else $error("master clock pin driven on external source");

  a_two_ch_frame:
    assert property ((s_master_rise and !is_tdm) |-> fall_cnt == 9'h040)
    else $error("two-channel frame not 64 bit clocks");

  a_tdm_frame:
    assert property ((s_master_rise and is_tdm) |-> fall_cnt == 9'h100)
    else $error("TDM frame not 256 bit clocks");

  a_zero_pad:
    assert property (running && shift && !is_tdm && !valid2 |=> dout == 4'h0)
    else $error("padding bits not zero");

  a_tdm_slot_pad:
    assert property (running && shift && is_tdm && !validt |=> !first_data_output_o)
    else $error("TDM slot tail not zero");

  a_tdm_compl:
    assert property (running && shift && is_tdm
                     |=> complementary_tdm_output_o == !first_data_output_o)
    else $error("complementary TDM output not inverted");

  a_start_bound:
    assert property (!running |-> start_cnt < 20'(START_CYCLES))
    else $error("start-up exceeded bound");

endmodule : sap_port

`default_nettype wire

// ### test/sap_far_end.sv
// Far-end clock master that feeds the port in slave mode
`timescale 1ns/1ps
`default_nettype none

module sap_far_end (
  input  wire logic       clk_i,
  input  wire logic       en_i,
  input  wire logic [7:0] half_i,
  input  wire logic [7:0] bits_i,
  output var  logic       bclk_o,
  output var  logic       fclk_o
);
  logic [7:0] hc;
  logic [7:0] bc;
  // Frame length may shrink mid-frame, so wrap on at-or-above
  wire  logic [7:0] last    = 8'(bits_i << 1) - 8'h01;
  wire  logic [7:0] next_bc = (bc >= last) ? 8'h00 : bc + 8'h01;

  // Both clocks divided from the shared clk_i; still while disabled
  always_ff @(posedge clk_i)
  begin
    if (!en_i)
    begin
      hc     <= 8'h00;
      bc     <= 8'h00;
      bclk_o <= 1'b0;
      fclk_o <= 1'b0;
    end
    else if (hc == half_i - 8'h01)
    begin
      hc     <= 8'h00;
      bclk_o <= ~bclk_o;
      if (bclk_o)
      begin
        bc     <= next_bc;
        fclk_o <= next_bc < bits_i; // Frame high carries the odd channel
      end
    end
    else
      hc <= hc + 8'h01;
  end
endmodule : sap_far_end
`default_nettype wire

// ### test/sap_port_tb.sv
// Self-checking bench for the serial audio clocking port
`timescale 1ns/1ps
`default_nettype none

module sap_port_tb;
  logic clk_i = 1'b0, rstn_i = 1'b0, rd = 1'b0, wr = 1'b0, xin = 1'b0;
  logic fh = 1'b0, fl = 1'b0, rh = 1'b0, rl = 1'b0, xen = 1'b0, pen = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdat = 32'h0, rdat;
  logic [1:0] dv = 2'h0;
  logic [7:0] ph = 8'h06, pw = 8'h28;
  logic [7:0][23:0] ch;
  logic wq, m_o, m_oe, bco, bcoe, fco, fcoe, d1, d2, d3, d4, rep, pbc, pfc, xdo, tk;
  logic [39:0] g2, g4;
  int error_cnt = 0, total_checks = 0, cyc = 0, takes = 0;
  // Observed clocks come from whoever drives the pins
  wire logic bclk = bcoe ? bco : pbc;
  wire logic fclk = fcoe ? fco : pfc;

  sap_port #(.START_CYCLES(16)) u_sap_port (.clk_i(clk_i), .rstn_i(rstn_i),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wq), .format_select_high_i(fh),
    .format_select_low_i(fl), .speed_role_select_high_i(rh), .speed_role_select_low_i(rl),
    .clock_divider_strap_i(dv), .crystal_enable_strap_i(xen), .crystal_clock_input_i(xin),
    .crystal_drive_output_o(xdo), .mclk_pin_i(xin), .mclk_pin_o(m_o), .mclk_pin_oe_o(m_oe),
    .bit_clock_pin_i(pbc), .bit_clock_pin_o(bco), .bit_clock_pin_oe_o(bcoe),
    .frame_clock_pin_i(pfc), .frame_clock_pin_o(fco), .frame_clock_pin_oe_o(fcoe),
    .first_data_output_o(d1), .second_data_output_o(d2), .complementary_tdm_output_o(d3),
    .fourth_data_output_o(d4), .ctrl_pins_repurposed_o(rep), .ch_sample_i(ch),
    .sample_take_o(tk));
  sap_far_end u_sap_far_end (.clk_i(clk_i), .en_i(pen), .half_i(ph), .bits_i(pw),
    .bclk_o(pbc), .fclk_o(pfc));

  initial forever #12.5 clk_i = ~clk_i;
  // Hang guard; also wiggles the crystal input
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    xin <= cyc[1];
    if (tk === 1'b1)
      takes <= takes + 1;
    if (cyc == 40000)
    begin
      error_cnt = error_cnt + 1;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [39:0] got, input logic [39:0] exp, input string what);
    total_checks = total_checks + 1;
    if (got !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("CHECK FAILED %0t %s got %h", $time, what, got);
    end
  endtask : check

  // One Avalon access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk_i);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdat <= d;
    do @(posedge clk_i); while (wq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  // Straps stay put across reset
  task automatic do_reset(input logic [1:0] f, input logic [1:0] r, input logic x);
    @(posedge clk_i);
    rstn_i <= 1'b0;
    {fh, fl} <= f;
    {rh, rl} <= r;
    xen <= x;
    pen <= 1'b0;
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
  endtask : do_reset

  task automatic frame_rise();
    logic pf;
    pf = 1'b1;
    repeat (4000)
    begin
      @(posedge clk_i);
      #1;
      if (fclk === 1'b1 && !pf)
        return;
      pf = fclk;
    end
    check(40'h1, 40'h0, "no frame start");
  endtask : frame_rise

  // Samples data on the bit clock rising edge
  task automatic grab(input int n, output logic [39:0] v, output logic [39:0] c);
    logic pb;
    v = 40'h0;
    c = 40'h0;
    g2 = 40'h0;
    g4 = 40'h0;
    pb = bclk;
    while (n > 0)
    begin
      @(posedge clk_i);
      #1;
      if (bclk === 1'b1 && !pb)
      begin
        v = {v[38:0], d1};
        c = {c[38:0], d3};
        g2 = {g2[38:0], d2};
        g4 = {g4[38:0], d4};
        n = n - 1;
      end
      pb = bclk;
    end
  endtask : grab

  task automatic count(output int n);
    logic pb;
    logic pf;
    frame_rise();
    n = 0;
    pb = 1'b0;
    pf = 1'b1;
    repeat (4000)
    begin
      @(posedge clk_i);
      #1;
      if (bclk === 1'b1 && !pb)
        n = n + 1;
      if (fclk === 1'b1 && !pf)
        return;
      pb = bclk;
      pf = fclk;
    end
  endtask : count

  task automatic t_regs();
    logic [31:0] q;
    do_reset(2'b00, 2'b00, 1'b0);
    bus(1'b0, sap_pkg::OFS_GLOBAL, 32'h0, q);
    check({8'h00, q}, 40'h0, "global reset value");
    bus(1'b0, sap_pkg::OFS_MODE, 32'h0, q);
    check({8'h00, q}, 40'h0, "mode reset value");
    bus(1'b0, 4'hC, 32'h0, q);
    check({8'h00, q}, 40'h0, "unmapped read");
    check({38'h0, m_o, xdo}, 40'h0, "mclk and crystal drive idle");
    check({39'h0, rep}, 40'h0, "pins still straps");
    check({39'h0, m_oe}, 40'h0, "mclk pin is input");
    bus(1'b1, sap_pkg::OFS_GLOBAL, 32'h0000_0080, q);
    bus(1'b1, sap_pkg::OFS_GLOBAL, 32'h0, q);
    bus(1'b0, sap_pkg::OFS_STATUS, 32'h0, q);
    check({39'h0, rep}, 40'h1, "pins repurposed");
    check({39'h0, q[sap_pkg::ST_CONTROL_PORT_ENABLE]}, 40'h1, "enable sticky");
    $display("t_regs done");
  endtask : t_regs

  task automatic t_lj_master();
    int n;
    logic [39:0] v, c;
    do_reset(2'b00, 2'b00, 1'b1);
    count(n);
    check(40'(n), 40'd64, "bit clocks per frame");
    check({38'h0, bcoe, fcoe}, 40'h3, "clocks driven");
    check({39'h0, m_oe}, 40'h1, "mclk pin drives");
    check({39'h0, m_o ^ xdo}, 40'h1, "crystal drive inverse");
    frame_rise();
    grab(32, v, c);
    check(v, {8'h00, ch[0], 8'h00}, "odd channel");
    check(g2, {8'h00, ch[2], 8'h00}, "second output odd");
    check(c, {8'h00, ch[4], 8'h00}, "third output odd");
    check(g4, {8'h00, ch[6], 8'h00}, "fourth output odd");
    grab(32, v, c);
    check(v, {8'h00, ch[1], 8'h00}, "even channel");
    $display("t_lj_master done");
  endtask : t_lj_master

  task automatic t_tdm_master();
    int n;
    logic [39:0] v, c;
    do_reset(2'b10, 2'b10, 1'b0);
    count(n);
    check(40'(n), 40'd256, "tdm bit clocks");
    frame_rise();
    grab(32, v, c);
    check(v, {8'h00, ch[0], 8'h00}, "slot 0");
    check(c[31:0] ^ v[31:0], 40'hFFFF_FFFF, "complement");
    check(g2 | g4, 40'h0, "tdm spare outputs low");
    grab(32, v, c);
    check(v, {8'h00, ch[1], 8'h00}, "slot 1");
    $display("t_tdm_master done");
  endtask : t_tdm_master

  // Double speed with divide-by-two strap; odd channel sits in frame low
  task automatic t_i2s_master();
    int n, k;
    logic [39:0] v, c;
    dv <= 2'h1;
    do_reset(2'b01, 2'b01, 1'b0);
    count(n);
    check(40'(n), 40'd64, "i2s bit clocks");
    frame_rise();
    k = takes;
    grab(32, v, c);
    check(v, {9'h000, ch[1], 7'h00}, "i2s even channel");
    grab(32, v, c);
    check(v, {9'h000, ch[0], 7'h00}, "i2s odd channel");
    frame_rise();
    check(40'(takes - k), 40'd1, "one take per frame");
    $display("t_i2s_master done");
  endtask : t_i2s_master

  task automatic t_slave();
    logic [31:0] q;
    logic [39:0] v, c;
    do_reset(2'b10, 2'b00, 1'b0);
    bus(1'b1, sap_pkg::OFS_GLOBAL, 32'h0000_0080, q);
    bus(1'b1, sap_pkg::OFS_MODE, 32'h0000_0003, q);
    pen <= 1'b1;
    repeat (3) frame_rise();
    check({38'h0, bcoe, fcoe}, 40'h0, "slave clocks in");
    grab(40, v, c);
    check(v, {ch[0], 16'h0000}, "zero padding");
    bus(1'b0, sap_pkg::OFS_STATUS, 32'h0, q);
    check({37'h0, q[2:0]}, 40'h0, "single speed slave");
    pw <= 8'h10;
    repeat (4) frame_rise();
    grab(16, v, c);
    check(v, {24'h0, ch[0][23:8]}, "truncation");
    bus(1'b0, sap_pkg::OFS_STATUS, 32'h0, q);
    check({38'h0, q[1:0]}, 40'h1, "double speed");
    bus(1'b1, sap_pkg::OFS_MODE, 32'h0000_000F, q);
    frame_rise();
    grab(16, v, c);
    check(v | c | g2 | g4, 40'h0, "reserved format silent");
    $display("t_slave done");
  endtask : t_slave

  initial
  begin
    for (int i = 0; i < 8; i++)
      ch[i] = 24'hC35A80 ^ 24'(i);
    t_regs();
    t_lj_master();
    t_tdm_master();
    t_i2s_master();
    t_slave();
    report_and_stop();
  end
endmodule : sap_port_tb
`default_nettype wire
